// ---- logic/tfdrp_pkg.sv ----
// Purpose: constants and types for the transmit FIFO RAM debug read port
// Assumes: 32-bit register words, 40-bit FIFO RAM words
// Notes:   field positions refer to the 40-bit FIFO word or the 32-bit register word
package tfdrp_pkg;

   // register word offsets
   localparam logic [9:0] TFDRP_OFS_CTRL    = 10'h068;
   localparam logic [9:0] TFDRP_OFS_LO_DATA = 10'h06C;

   // control word layout
   localparam int TFDRP_REQ_BIT     = 31;
   localparam int TFDRP_ACK_BIT     = 30;
   localparam int TFDRP_HI_MSB      = 23;
   localparam int TFDRP_HI_LSB      = 16;
   localparam int TFDRP_LOW_FIELD_W = 16;

   // upper byte of the 40-bit FIFO word
   localparam int TFDRP_FW_CTRL_FRAME = 39;
   localparam int TFDRP_FW_PAD_MSB    = 38;
   localparam int TFDRP_FW_PAD_LSB    = 37;
   localparam int TFDRP_FW_OVR_EN     = 36;
   localparam int TFDRP_FW_GEN_FCS    = 35;
   localparam int TFDRP_FW_EOF        = 34;
   localparam int TFDRP_FW_BV_MSB     = 33;
   localparam int TFDRP_FW_BV_LSB     = 32;
   localparam int TFDRP_FW_W          = 40;

   // last-word valid byte codes
   localparam logic [1:0] TFDRP_BV_ALL4 = 2'h0;
   localparam logic [1:0] TFDRP_BV_LOW3 = 2'h1;
   localparam logic [1:0] TFDRP_BV_LOW2 = 2'h2;
   localparam logic [1:0] TFDRP_BV_LOW1 = 2'h3;

   // reset values
   localparam logic [7:0]  TFDRP_HI_RST = 8'h00;
   localparam logic [31:0] TFDRP_LO_RST = 32'h0000_0000;

   // default RAM address width
   localparam int TFDRP_ADDR_W_DEF = 12;

   typedef enum logic [3:0] {
      TFDRP_IDLE  = 4'b0001,
      TFDRP_ISSUE = 4'b0010,
      TFDRP_CAPT  = 4'b0100,
      TFDRP_DONE  = 4'b1000
   } tfdrp_state_t;

endpackage : tfdrp_pkg

// ---- logic/tfdrp_handshake.sv ----
// Purpose: request/acknowledge sequencer for one debug read of the transmit FIFO RAM
// Assumes: RAM read data valid one clock after ram_rd_en
// Notes:   address is held from request to acknowledge, later writes do not disturb it
`timescale 1ns/1ps
module tfdrp_handshake #(
   parameter int ADDR_W = tfdrp_pkg::TFDRP_ADDR_W_DEF
) (
   input  logic                core_clk,
   input  logic                rst,
   input  logic                req,
   input  logic [ADDR_W+1:0]   addr,
   output logic                ack,
   output logic                ram_rd_en,
   output logic [ADDR_W-1:0]   ram_rd_addr,
   output logic                capture,
   output logic                sel_ptr
);
   import tfdrp_pkg::*;

   tfdrp_state_t               state_r;
   tfdrp_state_t               state_nxt;
   logic [ADDR_W+1:0]          addr_r;
   logic [ADDR_W+1:0]          addr_nxt;

   always_comb begin
      state_nxt = state_r;
      addr_nxt  = addr_r;
      unique case (state_r)
         TFDRP_IDLE: begin
            if (req) begin
               state_nxt = TFDRP_ISSUE;
               addr_nxt  = addr;
            end
         end
         TFDRP_ISSUE: state_nxt = TFDRP_CAPT;
         TFDRP_CAPT:  state_nxt = TFDRP_DONE;
         TFDRP_DONE: begin
            // ack only drops once software drops its request
            if (!req) begin
               state_nxt = TFDRP_IDLE; // RL1
            end
         end
         default: state_nxt = TFDRP_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= TFDRP_IDLE;
         addr_r  <= '0;
      end else begin
         state_r <= state_nxt;
         addr_r  <= addr_nxt;
      end
   end

   assign sel_ptr     = addr_r[ADDR_W+1];
   assign ram_rd_addr = addr_r[ADDR_W-1:0]; // RL5
   // pointer mode leaves the RAM untouched
   assign ram_rd_en   = (state_r == TFDRP_ISSUE) && !sel_ptr; // RL5 RL15
   assign capture     = (state_r == TFDRP_CAPT); // RL2 RL16
   assign ack         = (state_r == TFDRP_DONE); // RL1 RL2

   a_ram_addr_src: assert property (@(posedge core_clk) disable iff (rst) // RL5
      ram_rd_en |-> !addr_r[ADDR_W+1] && ram_rd_addr == $past(addr[ADDR_W-1:0]))
      else $error("ram read issued in pointer mode or with wrong address");

   a_ack_latency: assert property (@(posedge core_clk) disable iff (rst) // RL2
      (state_r == TFDRP_IDLE && req) |-> !ack ##1 !ack ##1 (!ack && capture) ##1 ack)
      else $error("acknowledge not raised three cycles after request");

   a_ack_rise_cause: assert property (@(posedge core_clk) disable iff (rst) // RL1
      $rose(ack) |-> $past(req, 3))
      else $error("acknowledge rose without a request");

   a_ack_fall_cause: assert property (@(posedge core_clk) disable iff (rst) // RL1
      $fell(ack) |-> !$past(req))
      else $error("acknowledge fell while request still high");

   c_ram_read: cover property (@(posedge core_clk) disable iff (rst)
      ram_rd_en ##2 ack);
   c_ptr_read: cover property (@(posedge core_clk) disable iff (rst)
      (capture && sel_ptr) ##1 ack);
   c_full_cycle: cover property (@(posedge core_clk) disable iff (rst)
      ack ##1 !ack ##[1:10] ack);

endmodule : tfdrp_handshake

// ---- logic/tfdrp_read_port.sv ----
// Purpose: debug read port into the transmit FIFO RAM with its control and data registers
// Assumes: RAM, transmit pointer and register port all run on core_clk
// Notes:   register reads return one clock after reg_rd_en, unmapped offsets read zero
//
// Function
// RL1 - the acknowledge changes only after the request changes, rising after it rises and falling after it falls.
// RL2 - a raised acknowledge means the address was taken and the addressed word sits in the read data fields.
// RL3 - the acknowledge bit is read-only and a write to it leaves it unchanged.
// RL4 - bits 23:16 show the upper byte of the read word read-only, reset to zero, writes ignored.
// RL5 - with the pointer-select bit clear the word comes from the RAM at the low address bits.
// RL6 - bit 39 of the word is one for a control frame and zero for an ordinary frame.
// RL7 - bits 38:37 of the word hold the per-packet padding mode.
// RL8 - bit 36 of the word holds the per-packet override enable.
// RL9 - bit 35 of the word holds the per-packet request to append the frame check sequence.
// RL10 - bit 34 of the word marks the last word of a frame.
// RL11 - bits 33:32 give the valid bytes of a last word: 0 all four, 1 low three, 2 low two, 3 low one.
// RL12 - the read data field is read-only and writes do not alter it.
// RL13 - the low field up to bit width+1 is a read-write address field that resets to zero.
// RL14 - software raises the request only with the acknowledge low and the transmit path idle, and drops it only after the acknowledge.
// RL15 - with the pointer-select bit set the transmit pointer is returned in the address field instead of a RAM word.
// RL16 - upper byte and lower four bytes of one word are captured in one handshake.
`timescale 1ns/1ps
module tfdrp_read_port #(
   parameter int tx_ram_addr_width_param = tfdrp_pkg::TFDRP_ADDR_W_DEF
) (
   input  logic                                     core_clk,
   input  logic                                     rst,
   input  logic                                     reg_wr_en,
   input  logic                                     reg_rd_en,
   input  logic [9:0]                               reg_addr,
   input  logic [31:0]                              reg_wdata,
   output logic [31:0]                              reg_rdata,
   output logic                                     ram_rd_en,
   output logic [tx_ram_addr_width_param-1:0]       ram_rd_addr,
   input  logic [tfdrp_pkg::TFDRP_FW_W-1:0]         ram_rd_data,
   input  logic [tx_ram_addr_width_param:0]         tx_ptr
);
   import tfdrp_pkg::*;

   localparam int AW = tx_ram_addr_width_param;

   logic                wr_ctrl;
   logic                wr_lo;
   logic                ack;
   logic                capture;
   logic                sel_ptr;
   logic                req_r;
   logic                req_nxt;
   logic [AW+1:0]       addr_r;
   logic [AW+1:0]       addr_nxt;
   logic [7:0]          hi_r;
   logic [7:0]          hi_nxt;
   logic [31:0]         lo_r;
   logic [31:0]         lo_nxt;
   logic [AW:0]         ptr_r;
   logic [AW:0]         ptr_nxt;
   logic [31:0]         rdata_r;
   logic [31:0]         rdata_nxt;
   logic [AW+1:0]       addr_view;
   logic [15:0]         low_half;

   assign wr_ctrl = reg_wr_en && (reg_addr == TFDRP_OFS_CTRL);
   assign wr_lo   = reg_wr_en && (reg_addr == TFDRP_OFS_LO_DATA);

   tfdrp_handshake #(
      .ADDR_W      (AW)
   ) u_handshake (
      .core_clk    (core_clk),
      .rst         (rst),
      .req         (req_r),
      .addr        (addr_r),
      .ack         (ack),
      .ram_rd_en   (ram_rd_en),
      .ram_rd_addr (ram_rd_addr),
      .capture     (capture),
      .sel_ptr     (sel_ptr)
   );

   // register state: only request and address are writable
   always_comb begin
      req_nxt  = req_r;
      addr_nxt = addr_r;
      hi_nxt   = hi_r;
      lo_nxt   = lo_r;
      ptr_nxt  = ptr_r;
      if (wr_ctrl) begin
         req_nxt  = reg_wdata[TFDRP_REQ_BIT]; // RL1
         addr_nxt = reg_wdata[AW+1:0]; // RL13
      end
      // wr_lo and the ack/data bits of wr_ctrl are deliberately dropped
      if (capture) begin
         if (sel_ptr) begin
            ptr_nxt = tx_ptr; // RL15
         end else begin
            // control flags, pad mode, override, fcs, eof, byte code kept as stored
            hi_nxt = ram_rd_data[TFDRP_FW_CTRL_FRAME:TFDRP_FW_BV_LSB]; // RL4 RL6 RL7 RL8 RL9 RL10 RL11
            lo_nxt = ram_rd_data[TFDRP_FW_BV_LSB-1:0]; // RL12 RL16
         end
      end
   end

   always_comb begin
      addr_view = sel_ptr ? {1'b1, ptr_r} : addr_r; // RL15
      low_half  = '0;
      low_half[AW+1:0] = addr_view; // RL13
      rdata_nxt = rdata_r;
      if (reg_rd_en) begin
         if (reg_addr == TFDRP_OFS_CTRL) begin
            rdata_nxt = {req_r, ack, 6'h00, hi_r, low_half}; // RL3 RL4
         end else if (reg_addr == TFDRP_OFS_LO_DATA) begin
            rdata_nxt = lo_r; // RL12
         end else begin
            rdata_nxt = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         req_r   <= 1'b0;
         addr_r  <= '0;
         hi_r    <= TFDRP_HI_RST;
         lo_r    <= TFDRP_LO_RST;
         ptr_r   <= '0;
         rdata_r <= 32'h0000_0000;
      end else begin
         req_r   <= req_nxt;
         addr_r  <= addr_nxt;
         hi_r    <= hi_nxt;
         lo_r    <= lo_nxt;
         ptr_r   <= ptr_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   a_ack_write_ignored: assert property (@(posedge core_clk) disable iff (rst) // RL3
      wr_ctrl |=> $stable(ack))
      else $error("write to control word moved the acknowledge at once");

   a_data_write_ignored: assert property (@(posedge core_clk) disable iff (rst) // RL12
      (reg_wr_en && !capture) |=> ($stable(hi_r) && $stable(lo_r)))
      else $error("register write changed captured read data");

   a_hi_byte_map: assert property (@(posedge core_clk) disable iff (rst) // RL4
      (capture && !sel_ptr) |=> hi_r == $past(ram_rd_data[39:32]))
      else $error("upper byte does not match RAM bits 39:32");

   a_word_pairing: assert property (@(posedge core_clk) disable iff (rst) // RL16
      (capture && !sel_ptr) |=> (lo_r == $past(ram_rd_data[31:0])) ##1 (ack && $stable(lo_r)))
      else $error("lower bytes not captured with upper byte");

   a_ptr_return: assert property (@(posedge core_clk) disable iff (rst) // RL15
      (capture && sel_ptr) |=> (ptr_r == $past(tx_ptr)) && $stable(hi_r) && $stable(lo_r))
      else $error("pointer read did not return transmit pointer");

   a_addr_write: assert property (@(posedge core_clk) disable iff (rst) // RL13
      wr_ctrl |=> addr_r == $past(reg_wdata[AW+1:0]))
      else $error("address field did not take written value");

   a_ctrl_readback: assert property (@(posedge core_clk) disable iff (rst) // RL1
      (reg_rd_en && reg_addr == TFDRP_OFS_CTRL) |=>
      (reg_rdata[TFDRP_ACK_BIT] == $past(ack) && reg_rdata[29:24] == 6'h00))
      else $error("control readback wrong");

   // field by field, so a swapped flag is named in the failure
   a_ctrl_frame_flag: assert property (@(posedge core_clk) disable iff (rst) // RL6
      (capture && !sel_ptr) |=> hi_r[7] == $past(ram_rd_data[TFDRP_FW_CTRL_FRAME]))
      else $error("control frame flag not taken from word bit 39");

   a_pad_mode_bits: assert property (@(posedge core_clk) disable iff (rst) // RL7
      (capture && !sel_ptr) |=>
      hi_r[6:5] == $past(ram_rd_data[TFDRP_FW_PAD_MSB:TFDRP_FW_PAD_LSB]))
      else $error("padding mode not taken from word bits 38:37");

   a_override_bit: assert property (@(posedge core_clk) disable iff (rst) // RL8
      (capture && !sel_ptr) |=> hi_r[4] == $past(ram_rd_data[TFDRP_FW_OVR_EN]))
      else $error("override enable not taken from word bit 36");

   a_fcs_req_bit: assert property (@(posedge core_clk) disable iff (rst) // RL9
      (capture && !sel_ptr) |=> hi_r[3] == $past(ram_rd_data[TFDRP_FW_GEN_FCS]))
      else $error("check sequence request not taken from word bit 35");

   a_eof_mark: assert property (@(posedge core_clk) disable iff (rst) // RL10
      (capture && !sel_ptr) |=> hi_r[2] == $past(ram_rd_data[TFDRP_FW_EOF]))
      else $error("end of frame mark not taken from word bit 34");

   a_byte_code: assert property (@(posedge core_clk) disable iff (rst) // RL11
      (capture && !sel_ptr) |=>
      hi_r[1:0] == $past(ram_rd_data[TFDRP_FW_BV_MSB:TFDRP_FW_BV_LSB]))
      else $error("valid byte code not taken from word bits 33:32");

   a_hi_readback: assert property (@(posedge core_clk) disable iff (rst) // RL4
      (reg_rd_en && reg_addr == TFDRP_OFS_CTRL) |=>
      reg_rdata[TFDRP_HI_MSB:TFDRP_HI_LSB] == $past(hi_r))
      else $error("upper byte not shown in control word bits 23:16");

   a_lo_readback: assert property (@(posedge core_clk) disable iff (rst) // RL12
      (reg_rd_en && reg_addr == TFDRP_OFS_LO_DATA) |=> reg_rdata == $past(lo_r))
      else $error("low data word readback wrong");

   a_addr_readback: assert property (@(posedge core_clk) disable iff (rst) // RL13
      (reg_rd_en && reg_addr == TFDRP_OFS_CTRL && !sel_ptr) |=>
      reg_rdata[AW+1:0] == $past(addr_r))
      else $error("address field readback wrong");

   a_ptr_readback: assert property (@(posedge core_clk) disable iff (rst) // RL15
      (reg_rd_en && reg_addr == TFDRP_OFS_CTRL && sel_ptr) |=>
      reg_rdata[AW+1:0] == {1'b1, $past(ptr_r)})
      else $error("pointer not shown in address field");

   a_req_readback: assert property (@(posedge core_clk) disable iff (rst) // RL1
      (reg_rd_en && reg_addr == TFDRP_OFS_CTRL) |=>
      reg_rdata[TFDRP_REQ_BIT] == $past(req_r))
      else $error("request bit readback wrong");

   a_data_held: assert property (@(posedge core_clk) disable iff (rst) // RL2
      ack |=> ($stable(hi_r) && $stable(lo_r)))
      else $error("read data moved while acknowledge high");

   a_ptr_no_ram: assert property (@(posedge core_clk) disable iff (rst) // RL15
      (capture && sel_ptr) |-> !$past(ram_rd_en))
      else $error("pointer read touched the RAM");

   c_data_read: cover property (@(posedge core_clk) disable iff (rst)
      (capture && !sel_ptr && ram_rd_data[34]) ##1 ack);

endmodule : tfdrp_read_port

// ---- sim/tx_fifo_ram_debug_read_port_bench.sv ----
// Purpose: self-checking bench for the transmit FIFO RAM debug read port
// Assumes: RAM answers one clock after ram_rd_en, tx_ptr steady during a read
// Notes:   bench stands in for host software, the FIFO RAM and the transmit module
`timescale 1ns/1ps
module tx_fifo_ram_debug_read_port_bench;
   import tfdrp_pkg::*;
   localparam int AW = 12;
   logic                  core_clk;
   logic                  rst;
   logic                  reg_wr_en;
   logic                  reg_rd_en;
   logic [9:0]            reg_addr;
   logic [31:0]           reg_wdata;
   logic [31:0]           reg_rdata;
   logic                  ram_rd_en;
   logic [AW-1:0]         ram_rd_addr;
   logic [AW-1:0]         ram_addr_q;
   logic [TFDRP_FW_W-1:0] ram_rd_data;
   logic                  ram_seen;
   logic [AW:0]           tx_ptr;
   int                    miscompares;
   int                    n_compared;
   int                    ram_hits;
   logic [7:0]            hi_tab [4] = '{8'hA4, 8'h59, 8'h36, 8'hCF};
   logic [AW-1:0]         addr_tab [4] = '{12'h000, 12'h5A5, 12'h5A6, 12'hFFF};

   tfdrp_read_port #(.tx_ram_addr_width_param(AW)) uut (
      .core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .ram_rd_en(ram_rd_en), .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data),
      .tx_ptr(tx_ptr));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   function automatic logic [39:0] ram_word(input logic [AW-1:0] a);
      return {hi_tab[a[1:0]], 4'hC, a, 4'h3, a};
   endfunction : ram_word

   // ram model: outside its valid cycle the data bus toggles so stale data never matches
   always @(posedge core_clk) begin
      ram_seen <= ram_rd_en;
      ram_addr_q <= ram_rd_addr;
      if (ram_rd_en === 1'b1) ram_hits++;
   end
   always @(negedge core_clk) begin
      ram_rd_data <= (ram_seen === 1'b1) ? ram_word(ram_addr_q) : ~ram_rd_data;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(negedge core_clk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [31:0] d);
      @(negedge core_clk);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd_en = 1'b0;
      d = reg_rdata;
   endtask : rd

   // bounded poll of the acknowledge bit
   task automatic wait_ack(input logic v, output logic [31:0] d);
      for (int i = 0; i < 20; i++) begin
         rd(TFDRP_OFS_CTRL, d);
         if (d[TFDRP_ACK_BIT] === v) break;
      end
   endtask : wait_ack

   task automatic t_reset;
      logic [31:0] d;
      rd(TFDRP_OFS_CTRL, d);
      chk(d, 32'h0000_0000);
      rd(TFDRP_OFS_LO_DATA, d);
      chk(d, TFDRP_LO_RST);
      rd(10'h070, d);
      chk(d, 32'h0000_0000);
   endtask : t_reset

   // one word per valid-byte code, lowest and highest address included
   task automatic t_ram_reads;
      logic [31:0] d;
      logic [39:0] w;
      logic [13:0] f;
      for (int k = 0; k < 4; k++) begin
         w = ram_word(addr_tab[k]);
         f = {2'b00, addr_tab[k]};
         wr(TFDRP_OFS_CTRL, {1'b1, 15'h0000, 2'b00, f});
         wait_ack(1'b1, d);
         chk(d, {2'b11, 6'h00, w[39:32], 2'b00, f});
         rd(TFDRP_OFS_LO_DATA, d);
         chk(d, w[31:0]);
         wr(TFDRP_OFS_CTRL, {1'b1, 1'b0, 6'h00, ~w[39:32], 2'b00, f});
         wr(TFDRP_OFS_LO_DATA, ~w[31:0]);
         rd(TFDRP_OFS_CTRL, d);
         chk(d, {2'b11, 6'h00, w[39:32], 2'b00, f});
         rd(TFDRP_OFS_LO_DATA, d);
         chk(d, w[31:0]);
         wr(TFDRP_OFS_CTRL, {18'h0_0000, f});
         wait_ack(1'b0, d);
         chk(d, {2'b00, 6'h00, w[39:32], 2'b00, f});
      end
      repeat (10) @(negedge core_clk);
      rd(TFDRP_OFS_CTRL, d);
      chk(d, {2'b00, 6'h00, w[39:32], 2'b00, f});
   endtask : t_ram_reads

   // pointer mode must not touch the RAM nor the data fields
   task automatic t_ptr_read;
      logic [31:0] d;
      logic [39:0] w;
      int          hits;
      w = ram_word(addr_tab[3]);
      hits = ram_hits;
      tx_ptr = 13'h1A5C;
      wr(TFDRP_OFS_CTRL, {1'b1, 15'h0000, 2'b00, 1'b1, 13'h0000});
      wait_ack(1'b1, d);
      chk(d, {2'b11, 6'h00, w[39:32], 2'b00, 1'b1, tx_ptr});
      rd(TFDRP_OFS_LO_DATA, d);
      chk(d, w[31:0]);
      chk(32'(ram_hits - hits), 32'h0000_0000);
      wr(TFDRP_OFS_CTRL, {18'h0_0000, 1'b1, 13'h0000});
      wait_ack(1'b0, d);
      chk({31'h0000_0000, d[TFDRP_ACK_BIT]}, 32'h0000_0000);
   endtask : t_ptr_read

   task automatic close_out;
      $display("mismatches %0d of %0d comparisons", miscompares, n_compared);
      if (miscompares == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   // whole run needs well under 1000 cycles
   initial begin
      #(25 * 4000);
      miscompares++;
      close_out;
   end

   initial begin
      rst = 1'b1;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 32'h0000_0000;
      ram_rd_data = 40'h00_0000_0000;
      tx_ptr = 13'h0000;
      miscompares = 0;
      n_compared = 0;
      ram_hits = 0;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset;
      t_ram_reads;
      t_ptr_read;
      close_out;
   end
endmodule : tx_fifo_ram_debug_read_port_bench
